/* twc_pkg.sv */
// Purpose: shared constants and carriers for the two-way write-through cache
// Assumes: one synchronous clock, 22-bit physical byte addresses
// Notes: tag is 12 bits, index 8 bits, word and byte select 2 bits
package twc_pkg;
    localparam int TWC_AW      = 22;
    localparam int TWC_DW      = 16;
    localparam int TWC_IDX_W   = 8;
    localparam int TWC_IDX_LSB = 2;
    localparam int TWC_TAG_W   = 12;
    localparam int TWC_TAG_LSB = 10;
    localparam int TWC_SETS    = 256;
    localparam int TWC_WORDS   = 1024;
    localparam logic [15:0] TWC_LFSR_SEED = 16'hace1;

    // processor request
    typedef struct packed {
        logic [TWC_AW-1:0] addr;
        logic              wr;
        logic              byte_op;
        logic [TWC_DW-1:0] wdata;
    } twc_req_t;

    // main-memory request
    typedef struct packed {
        logic [TWC_AW-1:0] addr;
        logic              wr;
        logic              byte_op;
        logic [TWC_DW-1:0] wdata;
    } twc_mreq_t;

    // stored tag entry: two parity bits over valid and tag
    typedef struct packed {
        logic [1:0]           par;
        logic                 valid;
        logic [TWC_TAG_W-1:0] tag;
    } twc_tag_t;

    // data word with one parity bit per byte
    typedef struct packed {
        logic [1:0]        par;
        logic [TWC_DW-1:0] data;
    } twc_word_t;

    typedef enum logic [4:0] {
        TWC_IDLE  = 5'h01,
        TWC_LOOK  = 5'h02,
        TWC_FILL0 = 5'h04,
        TWC_FILL1 = 5'h08,
        TWC_WRITE = 5'h10
    } twc_state_t;
endpackage : twc_pkg

/* twc_cache.sv */
// Purpose: two-way set-associative write-through cache, 1024 words
// Assumes: memory answers each request with a one-cycle mem_ack pulse
// Notes: read lookup parity errors trap and retry from memory; abort on fill errors in the requested word, trap only in the other word
`timescale 1ns/1ns
module twc_cache
    import twc_pkg::*;
(
    // clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    // processor side
    input  wire logic            cpu_req,
    input  wire twc_req_t        cpu_cmd,
    output logic                 cpu_ack,
    output logic [TWC_DW-1:0]    cpu_rdata_q,
    output logic                 cpu_abort,
    output logic                 cpu_trap,
    // main-memory side
    output logic                 mem_req,
    output twc_mreq_t            mem_cmd_q,
    input  wire logic            mem_ack,
    input  wire logic [TWC_DW-1:0] mem_rdata,
    input  wire logic [1:0]      mem_rpar
);
    // storage arrays, one per group
    twc_tag_t  tag_q  [2][TWC_SETS];
    twc_word_t data_q [2][TWC_SETS][2];
    logic [TWC_SETS-1:0] valid_q [2];

    twc_state_t state_q;
    twc_req_t   req_q;
    logic [15:0] lfsr_q;
    logic        way_q;
    logic        abort_q, trap_q;

    function automatic logic [1:0] bpar(input logic [TWC_DW-1:0] d);
        bpar = {^d[15:8], ^d[7:0]};
    endfunction : bpar

    function automatic logic [1:0] tpar(input logic v,
                                        input logic [TWC_TAG_W-1:0] t);
        tpar = {^{v, t[11:6]}, ^t[5:0]};
    endfunction : tpar

    // address split
    logic [TWC_IDX_W-1:0] idx;
    logic [TWC_TAG_W-1:0] rtag;
    logic                 wsel, bsel;
    assign idx  = req_q.addr[TWC_IDX_LSB +: TWC_IDX_W];
    assign rtag = req_q.addr[TWC_TAG_LSB +: TWC_TAG_W];
    assign wsel = req_q.addr[1];
    assign bsel = req_q.addr[0];

    // lookup in both groups
    logic [1:0] hit_w, tbad_w, dbad_w;
    twc_word_t  rd_w [2];
    for (genvar g = 0; g < 2; g++) begin : g_look
        twc_tag_t t;
        assign t         = tag_q[g][idx];
        assign rd_w[g]   = data_q[g][idx][wsel];
        assign tbad_w[g] = valid_q[g][idx] &&
                           (t.par != tpar(1'b1, t.tag));
        assign hit_w[g]  = valid_q[g][idx] && !tbad_w[g] &&
                           (t.tag == rtag);
        assign dbad_w[g] = hit_w[g] &&
                           (rd_w[g].par != bpar(rd_w[g].data));
    end

    logic hit, hway, dbad, tbad;
    assign hway = hit_w[1] & ~hit_w[0];
    assign hit  = |hit_w;
    assign dbad = dbad_w[hway];
    assign tbad = |tbad_w;

    // write data merge for byte writes
    logic [TWC_DW-1:0] merged;
    always_comb begin
        merged = rd_w[hway].data;
        if (!req_q.byte_op)
            merged = req_q.wdata;
        else if (bsel)
            merged[15:8] = req_q.wdata[15:8];
        else
            merged[7:0] = req_q.wdata[7:0];
    end

    // memory parity check on fill words
    logic mbad;
    assign mbad = (mem_rpar != bpar(mem_rdata));

    // handshake outputs
    logic look_ok;
    assign look_ok = (state_q == TWC_LOOK) && !req_q.wr && hit &&
                     !dbad && !tbad;
    assign mem_req   = (state_q == TWC_FILL0) ||
                       (state_q == TWC_FILL1) ||
                       (state_q == TWC_WRITE);
    assign cpu_ack   = look_ok ||
                       ((state_q == TWC_FILL0 || state_q == TWC_FILL1 ||
                         state_q == TWC_WRITE) && mem_ack &&
                        state_q == TWC_WRITE) ||
                       ((state_q == TWC_FILL1) && mem_ack);
    assign cpu_abort = abort_q;
    assign cpu_trap  = trap_q;

    // free-running random source for way choice
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            lfsr_q <= TWC_LFSR_SEED;
        else
            lfsr_q <= {lfsr_q[14:0],
                       lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end

    // sequencer: fills run even word first, requested word flagged
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= TWC_IDLE;
            req_q     <= '0;
            mem_cmd_q <= '0;
            way_q     <= 1'b0;
        end else begin
            case (state_q)
                TWC_IDLE: begin
                    if (cpu_req) begin
                        req_q   <= cpu_cmd;
                        state_q <= TWC_LOOK;
                    end
                end
                TWC_LOOK: begin
                    if (req_q.wr) begin
                        mem_cmd_q <= {req_q.addr, 1'b1, req_q.byte_op,
                                      req_q.wdata};
                        state_q   <= TWC_WRITE;
                    end else if (!hit || dbad || tbad) begin
                        // a parity refill rewrites the faulty entry in place
                        way_q     <= dbad ? hway :
                                     tbad ? !tbad_w[0] :
                                     lfsr_q[0];
                        mem_cmd_q <= {req_q.addr[TWC_AW-1:2], 2'b00,
                                      1'b0, 1'b0, 16'h0000};
                        state_q   <= TWC_FILL0;
                    end else begin
                        state_q   <= TWC_IDLE;
                    end
                end
                TWC_FILL0: begin
                    if (mem_ack) begin
                        mem_cmd_q.addr[1] <= 1'b1;
                        state_q <= (mbad && !wsel) ? TWC_IDLE : TWC_FILL1;
                    end
                end
                TWC_FILL1, TWC_WRITE: begin
                    if (mem_ack)
                        state_q <= TWC_IDLE;
                end
                default: state_q <= TWC_IDLE;
            endcase
        end
    end

    // returned read data
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            cpu_rdata_q <= 16'h0000;
        else if (look_ok)
            cpu_rdata_q <= rd_w[hway].data;
        else if (mem_ack && (state_q == TWC_FILL0 ||
                             state_q == TWC_FILL1) &&
                 (state_q == TWC_FILL1) == wsel)
            cpu_rdata_q <= mem_rdata;
    end

    // parity reporting: abort for requested fill word, trap for read lookups and the other fill word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            abort_q <= 1'b0;
            trap_q  <= 1'b0;
        end else begin
            abort_q <= mem_ack && mbad &&
                       ((state_q == TWC_FILL0 && !wsel) ||
                        (state_q == TWC_FILL1 && wsel));
            trap_q  <= (state_q == TWC_LOOK && !req_q.wr &&
                        (dbad || tbad)) ||
                       (mem_ack && mbad &&
                        ((state_q == TWC_FILL0 && wsel) ||
                         (state_q == TWC_FILL1 && !wsel)));
        end
    end

    // valid flags: cleared at reset, set when a block is loaded
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            valid_q[0] <= '0;
            valid_q[1] <= '0;
        end else if (state_q == TWC_FILL1 && mem_ack) begin
            valid_q[way_q][idx] <= 1'b1;
        end else if (state_q == TWC_FILL0 && mem_ack) begin
            valid_q[way_q][idx] <= 1'b0;   // half-filled block not usable
        end
    end

    // tag and data arrays carry no reset; valid flags gate them
    always_ff @(posedge clock) begin
        if ((state_q == TWC_FILL0 || state_q == TWC_FILL1) && mem_ack) begin
            data_q[way_q][idx][state_q == TWC_FILL1] <=
                {bpar(mem_rdata), mem_rdata};
            tag_q[way_q][idx] <= {tpar(1'b1, rtag), 1'b1, rtag};
        end else if (state_q == TWC_LOOK && req_q.wr && hit && !dbad) begin
            data_q[hway][idx][wsel] <= {bpar(merged), merged};
        end
    end

    // checks
    AST_HIT_NO_MEM: assert property (@(posedge clock) disable iff (!rst_n)
        look_ok |=> state_q == TWC_IDLE && !mem_req)
        else $error("read hit started a memory cycle");
    AST_WRITE_THROUGH: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == TWC_LOOK && req_q.wr) |=> mem_req && mem_cmd_q.wr)
        else $error("write not sent to memory");
    AST_WMISS_NOCHG: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == TWC_LOOK && req_q.wr && !hit) |=>
        $stable(valid_q[0]) && $stable(valid_q[1]))
        else $error("write miss altered valid flags");
    AST_FILL_VALID: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == TWC_FILL1 && mem_ack) |=> valid_q[way_q][idx])
        else $error("filled block not valid");
    AST_MISS_FILL: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == TWC_LOOK && !req_q.wr && !hit) |=>
        state_q == TWC_FILL0 && mem_cmd_q.addr[1:0] == 2'b00)
        else $error("read miss did not fill block");
    AST_RESET_INVALID: assert property (@(posedge clock)
        $rose(rst_n) |-> valid_q[0] == '0 && valid_q[1] == '0)
        else $error("valid flags not clear after reset");
    AST_DBAD_TRAP: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == TWC_LOOK && !req_q.wr && dbad) |=>
        trap_q ##0 state_q == TWC_FILL0)
        else $error("data parity error not trapped");
    AST_TBAD_TRAP: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == TWC_LOOK && !req_q.wr && tbad) |=> trap_q)
        else $error("tag parity error not trapped");
    AST_FILL_ABORT: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == TWC_FILL0 && mem_ack && mbad && !wsel) |=>
        abort_q && !trap_q)
        else $error("bad requested word did not abort");
    AST_HIT_INDEX: assert property (@(posedge clock) disable iff (!rst_n)
        hit_w[0] |-> tag_q[0][idx].tag == rtag)
        else $error("hit without tag match");
    COV_RHIT:  cover property (@(posedge clock) look_ok);
    COV_FILL:  cover property (@(posedge clock)
        state_q == TWC_FILL1 && mem_ack);
    COV_WHIT:  cover property (@(posedge clock)
        state_q == TWC_LOOK && req_q.wr && hit);
    COV_TRAP:  cover property (@(posedge clock) trap_q);
endmodule : twc_cache

/* twc_mem_model.sv */
// Purpose: main-memory model that answers the cache's memory port
// Assumes: one request pending at a time, held until mem_ack
// Notes: slow adds wait cycles; bad_sel spoils parity of word 0 or 1
`timescale 1ns/1ns
module twc_mem_model
    import twc_pkg::*;
(
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // memory port
    input  wire logic         mem_req,
    input  wire twc_mreq_t    mem_cmd,
    output logic              mem_ack,
    output logic [TWC_DW-1:0] mem_rdata,
    output logic [1:0]        mem_rpar,
    // pace and fault controls
    input  wire logic         slow,
    input  wire logic [1:0]   bad_sel
);
    logic [TWC_DW-1:0] store [int];
    logic [TWC_DW-1:0] word_v;
    int                wait_n;

    // one ack per request; idle data toggles so stale values never match
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 16'h0000;
            mem_rpar  <= 2'h0;
            wait_n = 0;
        end else if (mem_req && !mem_ack && wait_n < (slow ? 3 : 0)) begin
            wait_n++;
        end else if (mem_req && !mem_ack) begin
            wait_n = 0;
            word_v = store.exists(int'(mem_cmd.addr[21:1])) ?
                     store[int'(mem_cmd.addr[21:1])] :
                     mem_cmd.addr[16:1] ^ 16'h5a3c;
            if (mem_cmd.wr && !mem_cmd.byte_op) word_v = mem_cmd.wdata;
            else if (mem_cmd.wr && mem_cmd.addr[0])
                word_v[15:8] = mem_cmd.wdata[15:8];
            else if (mem_cmd.wr) word_v[7:0] = mem_cmd.wdata[7:0];
            if (mem_cmd.wr) store[int'(mem_cmd.addr[21:1])] = word_v;
            mem_ack   <= 1'b1;
            mem_rdata <= word_v;
            // even byte parity, both bits spoiled on request
            mem_rpar  <= {^word_v[15:8], ^word_v[7:0]} ^
                         {2{bad_sel[mem_cmd.addr[1]]}};
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : twc_mem_model

/* testbench.sv */
// Purpose: self-checking bench for the write-through cache
// Assumes: memory model on the far side, inputs driven on falling edges
// Notes: replacement group is random, so no row depends on eviction
`timescale 1ns/1ns
module testbench;
    import twc_pkg::*;

    typedef struct packed {
        logic [TWC_AW-1:0] addr;
        logic              wr;
        logic              bop;
        logic [TWC_DW-1:0] wdata;
        logic [TWC_DW-1:0] exp;
        logic [3:0]        ncyc;
    } twc_row_t;

    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic              cpu_req = 1'b0;
    twc_req_t          cpu_cmd = '0;
    logic              cpu_ack, cpu_abort, cpu_trap, mem_req, mem_ack;
    logic [TWC_DW-1:0] cpu_rdata_q, mem_rdata, rd;
    twc_mreq_t         mem_cmd_q;
    logic [1:0]        mem_rpar;
    logic              slow = 1'b0;
    logic [1:0]        bad_sel = 2'h0;
    logic              got_ack, got_abort;
    int                mismatches, total_checks, mem_acks, traps, cyc;
    int                acks0, traps0, aborts, aborts0;
    twc_row_t          rows [11];

    // design and far-side memory
    twc_cache dut (.clock(clock), .rst_n(rst_n), .cpu_req(cpu_req),
        .cpu_cmd(cpu_cmd), .cpu_ack(cpu_ack), .cpu_rdata_q(cpu_rdata_q),
        .cpu_abort(cpu_abort), .cpu_trap(cpu_trap), .mem_req(mem_req),
        .mem_cmd_q(mem_cmd_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_rpar(mem_rpar));
    twc_mem_model mem (.clock(clock), .rst_n(rst_n), .mem_req(mem_req),
        .mem_cmd(mem_cmd_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_rpar(mem_rpar), .slow(slow), .bad_sel(bad_sel));

    // 100 ns clock
    always #50 clock = ~clock;

    // event counters and hang guard
    always @(posedge clock) begin
        cyc++;
        if (mem_ack) mem_acks++;
        if (cpu_trap) traps++;
        if (cpu_abort) aborts++;
        if (cyc == 3000) begin
            mismatches++;
            test_done();
        end
    end

    function automatic logic [15:0] memval(input logic [21:0] a);
        return a[16:1] ^ 16'h5a3c;
    endfunction : memval

    task automatic check(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one request: strobe for exactly one taking edge, then wait
    task automatic run_row(input twc_row_t r, input logic ack_exp);
        @(negedge clock);
        cpu_cmd = '{r.addr, r.wr, r.bop, r.wdata};
        cpu_req = 1'b1;
        acks0 = mem_acks;
        traps0 = traps;
        aborts0 = aborts;
        @(negedge clock);
        cpu_req = 1'b0;
        for (int n = 0; n < 60 && !(cpu_ack || cpu_abort); n++)
            @(negedge clock);
        got_ack = cpu_ack;
        got_abort = cpu_abort;
        @(negedge clock);
        rd = cpu_rdata_q;
        repeat (2) @(negedge clock);
        check("ack", 16'(got_ack), 16'(ack_exp));
        check("mem cycles", 16'(mem_acks - acks0), 16'(r.ncyc));
        if (!r.wr && ack_exp) check("rdata", rd, r.exp);
    endtask : run_row

    task automatic test_done;
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    initial begin
        rows = '{
            '{22'h001000, 1'b0, 1'b0, 16'h0, memval(22'h001000), 4'h2},
            '{22'h001002, 1'b0, 1'b0, 16'h0, memval(22'h001002), 4'h0},
            '{22'h001000, 1'b0, 1'b0, 16'h0, memval(22'h001000), 4'h0},
            '{22'h001004, 1'b0, 1'b0, 16'h0, memval(22'h001004), 4'h2},
            '{22'h001000, 1'b1, 1'b0, 16'h1234, 16'h0, 4'h1},
            '{22'h001000, 1'b0, 1'b0, 16'h0, 16'h1234, 4'h0},
            '{22'h001001, 1'b1, 1'b1, 16'h9999, 16'h0, 4'h1},
            '{22'h001000, 1'b0, 1'b0, 16'h0, 16'h9934, 4'h0},
            // same index, other tag: only after the block above is done
            '{22'h001400, 1'b0, 1'b0, 16'h0, memval(22'h001400), 4'h2},
            '{22'h003008, 1'b1, 1'b0, 16'habcd, 16'h0, 4'h1},
            '{22'h003008, 1'b0, 1'b0, 16'h0, 16'habcd, 4'h2}};
        repeat (2) @(negedge clock);
        check("mem_req in reset", 16'(mem_req), 16'h0);
        rst_n = 1'b1;
        // hits, misses, tag and index split, write-through, byte lane
        foreach (rows[i]) run_row(rows[i], 1'b1);
        // bad parity on the requested fill word aborts
        bad_sel = 2'h1;
        run_row('{22'h005000, 1'b0, 1'b0, 16'h0, 16'h0, 4'h1}, 1'b0);
        check("abort", 16'(got_abort), 16'h1);
        // bad parity on the other word completes, then traps
        bad_sel = 2'h2;
        run_row('{22'h006000, 1'b0, 1'b0, 16'h0, memval(22'h006000),
                  4'h2}, 1'b1);
        check("trap", 16'(traps - traps0), 16'h1);
        // bad parity on a requested odd word aborts after the second ack
        run_row('{22'h005002, 1'b0, 1'b0, 16'h0, memval(22'h005002),
                  4'h2}, 1'b1);
        check("late abort", 16'(aborts - aborts0), 16'h1);
        // slow memory, odd word requested
        bad_sel = 2'h0;
        slow = 1'b1;
        run_row('{22'h007002, 1'b0, 1'b0, 16'h0, memval(22'h007002),
                  4'h2}, 1'b1);
        // reset in mid-run must empty the cache again
        @(negedge clock);
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        run_row('{22'h001002, 1'b0, 1'b0, 16'h0, memval(22'h001002),
                  4'h2}, 1'b1);
        test_done();
    end
endmodule : testbench
